// [src/uv_forced_sleep.sv]
/*
 * Mode control with undervoltage forced sleep, forced-sleep status flag,
 * frame-detection error flag, captured wake-up events and wake configuration.
 * Assumes mode commands, configuration writes and event strobes come from
 * serial interface logic on the same clock; supply comparators are asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none

module uv_forced_sleep
	import uv_sleep_pkg::*;
#(
	parameter int VCC_DET_CYCLES = VCC_UV_DET_CYCLES,
	parameter int VIO_DET_CYCLES = VIO_UV_DET_CYCLES
) (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic i_vcc_uv,
	input wire logic i_vio_uv,
	input wire logic i_overtemp,
	input wire logic i_mode_req,
	input wire mode_t i_mode_sel,
	input wire logic i_wake_event,
	input wire logic i_cfg_write,
	input wire wake_cfg_t i_cfg_data,
	input wire logic [EVENT_BITS-1:0] i_event_set,
	input wire logic [EVENT_BITS-1:0] i_event_clear,
	input wire logic i_frame_error_set,
	input wire logic i_frame_error_clear,
	output mode_t o_mode,
	output logic o_forced_sleep_flag,
	output logic o_frame_detect_error_flag,
	output wake_cfg_t o_wake_cfg,
	output logic [EVENT_BITS-1:0] o_events
);

	////////////////////////////////////////////////////////////////////////////
	// Supply qualification.

	logic vcc_det;
	logic vio_det;

	uv_filter #(
		.DET_CYCLES(VCC_DET_CYCLES)
	) u_vcc_filter (
		.i_sys_clk(i_sys_clk),
		.i_reset(i_reset),
		.i_uv_level(i_vcc_uv),
		.o_uv_detected(vcc_det)
	);

	uv_filter #(
		.DET_CYCLES(VIO_DET_CYCLES)
	) u_vio_filter (
		.i_sys_clk(i_sys_clk),
		.i_reset(i_reset),
		.i_uv_level(i_vio_uv),
		.o_uv_detected(vio_det)
	);

	////////////////////////////////////////////////////////////////////////////
	// State.

	mode_t mode_reg;
	mode_t mode_next;
	logic forced_sleep_flag_reg;
	logic forced_sleep_flag_next;
	logic frame_error_reg;
	logic frame_error_next;
	wake_cfg_t cfg_reg;
	wake_cfg_t cfg_next;
	logic [EVENT_BITS-1:0] events_reg;
	logic [EVENT_BITS-1:0] events_next;
	logic uv_any;
	logic forced_entry;
	logic cmd_sleep;

	// A forced entry happens once, when an undervoltage is seen outside sleep.
	assign uv_any = vcc_det | vio_det;
	assign forced_entry = uv_any && (mode_reg != MODE_SLEEP);
	// Only a sleep request that the mode logic really takes counts; overtemp refuses it.
	assign cmd_sleep = !forced_entry && (mode_next == MODE_SLEEP) && (mode_reg != MODE_SLEEP);

	// Mode transitions; undervoltage outranks commands and overtemperature.
	always_comb begin
		mode_next = mode_reg;
		if (forced_entry) begin
			mode_next = MODE_SLEEP;
		end else begin
			case (mode_reg)
				MODE_STANDBY, MODE_NORMAL: begin
					if (i_overtemp && mode_reg == MODE_NORMAL) begin
						mode_next = MODE_OVERTEMP;
					end else if (i_mode_req && i_mode_sel != MODE_OVERTEMP) begin
						mode_next = i_mode_sel;
					end
				end
				MODE_SLEEP: begin
					if (i_wake_event) begin
						mode_next = MODE_STANDBY;
					end else if (i_mode_req && i_mode_sel == MODE_STANDBY) begin
						mode_next = MODE_STANDBY;
					end
				end
				MODE_OVERTEMP: begin
					if (!i_overtemp) begin
						mode_next = MODE_STANDBY;
					end
				end
				default: begin
					mode_next = MODE_STANDBY;
				end
			endcase
		end
	end

	// Status flags; standby, normal and overtemp entries leave both untouched.
	always_comb begin
		forced_sleep_flag_next = forced_sleep_flag_reg;
		frame_error_next = frame_error_reg;
		if (forced_entry) begin
			forced_sleep_flag_next = 1'h1;
			frame_error_next = 1'h0;
		end else begin
			if (cmd_sleep) begin
				forced_sleep_flag_next = 1'h0;
			end
			if (i_frame_error_clear) begin
				frame_error_next = 1'h0;
			end
			if (i_frame_error_set) begin
				frame_error_next = 1'h1;
			end
		end
	end

	// Wake configuration and captured events; a new event beats a software clear.
	always_comb begin
		cfg_next = cfg_reg;
		events_next = events_reg;
		if (forced_entry) begin
			cfg_next = WAKE_CFG_FORCED;
			events_next = '0;
		end else begin
			if (i_cfg_write) begin
				cfg_next = i_cfg_data;
			end
			events_next = (events_reg & ~i_event_clear) | i_event_set;
		end
	end

	// Register all state.
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			mode_reg <= MODE_RESET;
			forced_sleep_flag_reg <= FORCED_SLEEP_FLAG_RESET;
			frame_error_reg <= FRAME_DETECT_ERROR_RESET;
			cfg_reg <= WAKE_CFG_RESET;
			events_reg <= EVENTS_RESET;
		end else begin
			mode_reg <= mode_next;
			forced_sleep_flag_reg <= forced_sleep_flag_next;
			frame_error_reg <= frame_error_next;
			cfg_reg <= cfg_next;
			events_reg <= events_next;
		end
	end

	assign o_mode = mode_reg;
	assign o_forced_sleep_flag = forced_sleep_flag_reg;
	assign o_frame_detect_error_flag = frame_error_reg;
	assign o_wake_cfg = cfg_reg;
	assign o_events = events_reg;

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_reset);

	chk_forced_sets_flag: assert property (
		forced_entry |=> (o_forced_sleep_flag && o_mode == MODE_SLEEP))
		else $error("forced entry did not set the status flag");

	chk_uv_forces_sleep: assert property (
		(uv_any && o_mode != MODE_SLEEP) |=> (o_mode == MODE_SLEEP))
		else $error("undervoltage did not force sleep");

	chk_events_cleared: assert property (
		forced_entry |=> (o_events == '0))
		else $error("events not cleared on forced entry");

	chk_wake_cfg_forced: assert property (
		forced_entry |=> (o_wake_cfg == WAKE_CFG_FORCED && o_mode == MODE_SLEEP))
		else $error("wake configuration not forced");

	chk_cmd_sleep_clears: assert property (
		cmd_sleep |=> (!o_forced_sleep_flag && o_mode == MODE_SLEEP))
		else $error("commanded sleep did not clear the status flag");

	chk_standby_keeps_flag: assert property (
		(o_mode != MODE_STANDBY) ##1 (o_mode == MODE_STANDBY)
		|-> (o_forced_sleep_flag == $past(o_forced_sleep_flag)))
		else $error("standby entry changed the status flag");

	chk_flag_kept_active: assert property (
		($changed(o_mode) && (o_mode == MODE_NORMAL || o_mode == MODE_OVERTEMP)) |-> $stable(o_forced_sleep_flag))
		else $error("normal or overtemp entry changed the status flag");

	chk_frame_err_forced: assert property (
		forced_entry |=> !o_frame_detect_error_flag)
		else $error("frame error flag not cleared on forced entry");

	chk_frame_err_stable: assert property (
		(!forced_entry && !i_frame_error_set && !i_frame_error_clear) |=> $stable(o_frame_detect_error_flag))
		else $error("frame error flag changed without cause");

	cov_forced_sleep: cover property (forced_entry ##1 o_forced_sleep_flag);
	cov_wake_after_forced: cover property (
		(o_mode == MODE_SLEEP && o_forced_sleep_flag) ##1 (o_mode == MODE_STANDBY && o_forced_sleep_flag));
	cov_cmd_sleep: cover property (cmd_sleep ##1 !o_forced_sleep_flag);
	cov_overtemp: cover property (o_mode == MODE_OVERTEMP);

endmodule : uv_forced_sleep

`default_nettype wire

// [pkg/uv_sleep_pkg.sv]
/*
 * Shared constants and types for the undervoltage forced-sleep mode logic.
 * Assumes a single 50 MHz system clock and plain ports toward the serial interface logic.
 */
`default_nettype none
package uv_sleep_pkg;

	// Operating modes, one-hot.
	typedef enum logic [3:0] {
		MODE_STANDBY = 4'h1,
		MODE_NORMAL = 4'h2,
		MODE_SLEEP = 4'h4,
		MODE_OVERTEMP = 4'h8
	} mode_t;

	// Wake and selective-wake configuration bits, carried together.
	typedef struct packed {
		logic bus_wake_enable;
		logic wake_pin_fall_enable;
		logic wake_pin_rise_enable;
		logic selective_wake_config;
	} wake_cfg_t;

	// Captured wake-up event registers span this address range.
	localparam logic [7:0] EVENT_ADDR_FIRST = 8'h61;
	localparam logic [7:0] EVENT_ADDR_LAST = 8'h64;
	localparam int EVENT_REG_COUNT = int'(EVENT_ADDR_LAST - EVENT_ADDR_FIRST) + 1;
	localparam int EVENT_REG_WIDTH = 8;
	localparam int EVENT_BITS = EVENT_REG_COUNT * EVENT_REG_WIDTH;

	// Reset values.
	localparam mode_t MODE_RESET = MODE_STANDBY;
	localparam logic FORCED_SLEEP_FLAG_RESET = 1'h0;
	localparam logic FRAME_DETECT_ERROR_RESET = 1'h0;
	localparam wake_cfg_t WAKE_CFG_RESET = 4'h0;
	localparam logic [EVENT_BITS-1:0] EVENTS_RESET = '0;

	// Configuration imposed on a forced entry: all wake sources on, selective wake off.
	localparam wake_cfg_t WAKE_CFG_FORCED = 4'hE;

	// Supply undervoltage detection times and clock rate.
	localparam int CLK_PERIOD_NS = 20;
	localparam int VCC_UV_DET_NS = 10000;
	localparam int VIO_UV_DET_NS = 10000;
	localparam int VCC_UV_DET_CYCLES = (VCC_UV_DET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int VIO_UV_DET_CYCLES = (VIO_UV_DET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : uv_sleep_pkg

`default_nettype wire

// [src/uv_filter.sv]
/*
 * Undervoltage qualifier for one supply: synchronises the comparator level and
 * reports an undervoltage once it has stood for longer than the detection time.
 * Assumes the comparator output is asynchronous to the system clock.
 */
`timescale 1ns/1ps
`default_nettype none

module uv_filter #(
	parameter int DET_CYCLES = 500,
	parameter int CNT_W = $clog2(DET_CYCLES + 2)
) (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic i_uv_level,
	output logic o_uv_detected
);

	logic sync1_reg;
	logic sync2_reg;
	logic [CNT_W-1:0] count_reg;
	logic [CNT_W-1:0] count_next;
	logic det_reg;
	logic det_next;

	localparam logic [CNT_W-1:0] LIMIT = CNT_W'(DET_CYCLES);

	// Two-stage synchroniser; only the second stage feeds the counter.
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			sync1_reg <= 1'h0;
			sync2_reg <= 1'h0;
		end else begin
			sync1_reg <= i_uv_level;
			sync2_reg <= sync1_reg;
		end
	end

	// Count while low supply persists; detect strictly beyond the limit.
	always_comb begin
		count_next = count_reg;
		det_next = 1'h0;
		if (!sync2_reg) begin
			count_next = '0;
		end else if (count_reg <= LIMIT) begin
			count_next = count_reg + CNT_W'(1);
		end
		if (sync2_reg && count_reg > LIMIT) begin
			det_next = 1'h1;
		end
	end

	// Counter and detection registers.
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			count_reg <= '0;
			det_reg <= 1'h0;
		end else begin
			count_reg <= count_next;
			det_reg <= det_next;
		end
	end

	assign o_uv_detected = det_reg;

endmodule : uv_filter

`default_nettype wire

// [bench/uv_host_model.sv]
/*
 * Host microcontroller stand-in that reads the two status flags on a read strobe.
 * Assumes the strobe comes from the bench on the system clock, changed at the falling edge.
 */
`timescale 1ns/1ps
`default_nettype none

module uv_host_model (
	input wire logic i_sys_clk,
	input wire logic i_read,
	input wire logic i_forced_sleep_flag,
	input wire logic i_frame_detect_error_flag,
	output logic o_forced_sleep_flag,
	output logic o_frame_detect_error_flag
);
	// Capture both flags together so one read sees one consistent state.
	always_ff @(posedge i_sys_clk) begin
		if (i_read) begin
			o_forced_sleep_flag <= i_forced_sleep_flag;
			o_frame_detect_error_flag <= i_frame_detect_error_flag;
		end
	end
endmodule : uv_host_model

`default_nettype wire

// [bench/uv_forced_sleep_tb_top.sv]
/*
 * Self-checking bench for the forced-sleep mode logic: commands, wake, supply faults.
 * Assumes short detection counts through the design parameters and one 50 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none

module uv_forced_sleep_tb_top
	import uv_sleep_pkg::*;
;
	localparam int DET = 4;
	logic clk = 1'h0, rst = 1'h1, vcc = 1'h0, vio = 1'h0, ot = 1'h0, req = 1'h0;
	logic wake = 1'h0, cw = 1'h0, fes = 1'h0, rd = 1'h0, fsf, fde, h_fsf, h_fde;
	mode_t sel = MODE_STANDBY;
	mode_t mode;
	wake_cfg_t cfg_d = 4'h0;
	wake_cfg_t cfg;
	logic [EVENT_BITS-1:0] ev_set = 32'h0;
	logic [EVENT_BITS-1:0] ev;
	int num_errors = 0;
	int n_compared = 0;

	uv_forced_sleep #(.VCC_DET_CYCLES(DET), .VIO_DET_CYCLES(DET)) uv_forced_sleep_i (
		.i_sys_clk(clk), .i_reset(rst), .i_vcc_uv(vcc), .i_vio_uv(vio), .i_overtemp(ot),
		.i_mode_req(req), .i_mode_sel(sel), .i_wake_event(wake), .i_cfg_write(cw),
		.i_cfg_data(cfg_d), .i_event_set(ev_set), .i_event_clear(32'h0),
		.i_frame_error_set(fes), .i_frame_error_clear(1'h0), .o_mode(mode),
		.o_forced_sleep_flag(fsf), .o_frame_detect_error_flag(fde), .o_wake_cfg(cfg), .o_events(ev));

	uv_host_model uv_host_model_i (.i_sys_clk(clk), .i_read(rd), .i_forced_sleep_flag(fsf),
		.i_frame_detect_error_flag(fde), .o_forced_sleep_flag(h_fsf), .o_frame_detect_error_flag(h_fde));

	// Free-running system clock.
	initial begin
		forever #10 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Every task is entered and left at a falling edge.
	task automatic tick();
		@(negedge clk);
	endtask : tick

	task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task automatic command(input mode_t m);
		req = 1'h1;
		sel = m;
		tick();
		req = 1'h0;
	endtask : command

	task automatic host_read(input logic e_fsf, input logic e_fde);
		rd = 1'h1;
		tick();
		rd = 1'h0;
		check("forced_sleep_flag", h_fsf, e_fsf);
		check("frame_detect_error_flag", h_fde, e_fde);
	endtask : host_read

	// Bounded wait for the forced entry after a supply fault.
	task automatic wait_sleep();
		for (int k = 0; k < 40 && mode !== MODE_SLEEP; k++) tick();
		check("mode", mode, MODE_SLEEP);
	endtask : wait_sleep

	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : end_sim

	////////////////////////////////////////////////////////////////////////////////
	// Cuts a hang short long after the sequence should have ended.
	initial begin
		#200000;
		num_errors++;
		end_sim();
	end

	// Main sequence.
	initial begin
		repeat (6) @(posedge clk);
		tick();
		rst = 1'h0;
		check("mode", mode, MODE_STANDBY);
		check("wake_cfg", cfg, 4'h0);
		check("events", ev, 32'h0);
		host_read(1'h0, 1'h0);
		fes = 1'h1;
		ev_set = 32'hA5A5A5A5;
		cw = 1'h1;
		cfg_d = 4'h1;
		tick();
		fes = 1'h0;
		ev_set = 32'h0;
		cw = 1'h0;
		command(MODE_SLEEP);
		check("mode", mode, MODE_SLEEP);
		host_read(1'h0, 1'h1);
		command(MODE_STANDBY);
		host_read(1'h0, 1'h1);
		vcc = 1'h1;
		wait_sleep();
		check("events", ev, 32'h0);
		check("wake_cfg", cfg, 4'hE);
		host_read(1'h1, 1'h0);
		vcc = 1'h0;
		repeat (6) tick();
		wake = 1'h1;
		tick();
		wake = 1'h0;
		check("mode", mode, MODE_STANDBY);
		host_read(1'h1, 1'h0);
		fes = 1'h1;
		tick();
		fes = 1'h0;
		command(MODE_NORMAL);
		host_read(1'h1, 1'h1);
		ot = 1'h1;
		tick();
		check("mode", mode, MODE_OVERTEMP);
		host_read(1'h1, 1'h1);
		// A sleep request in overtemp is refused and must not touch the status flag.
		command(MODE_SLEEP);
		check("mode", mode, MODE_OVERTEMP);
		host_read(1'h1, 1'h1);
		ot = 1'h0;
		repeat (2) tick();
		command(MODE_NORMAL);
		vio = 1'h1;
		repeat (2) tick();
		vio = 1'h0;
		repeat (DET + 6) tick();
		check("mode", mode, MODE_NORMAL);
		vio = 1'h1;
		wait_sleep();
		host_read(1'h1, 1'h0);
		vio = 1'h0;
		repeat (6) tick();
		command(MODE_STANDBY);
		check("mode", mode, MODE_STANDBY);
		host_read(1'h1, 1'h0);
		command(MODE_SLEEP);
		host_read(1'h0, 1'h0);
		// Forced entry, a frame error while asleep, then a mid-run reset brings both flags back to 0.
		command(MODE_STANDBY);
		vio = 1'h1;
		wait_sleep();
		vio = 1'h0;
		fes = 1'h1;
		tick();
		fes = 1'h0;
		host_read(1'h1, 1'h1);
		rst = 1'h1;
		repeat (2) tick();
		rst = 1'h0;
		check("mode", mode, MODE_STANDBY);
		host_read(1'h0, 1'h0);
		end_sim();
	end
endmodule : uv_forced_sleep_tb_top

`default_nettype wire
